/* File: alh_supervisor.sv */
// Axis limit and homing supervisor: hardware and software travel limits and four homing methods.
// Assumes step pulses come from the pulse train generator on sys_clk; switch pins are asynchronous.
//
// Functional notes
// - Software limits inactive until axis homed.
// - Hardware limit trip brakes with emergency deceleration.
// - Software limit stops motion at normal deceleration.
// - One run-time hardware limit enable bit.
// - Independent software limit enable bit.
// - Software bounds rewritable, used immediately.
// - Filter change needs 20 ms low accumulation.
// - Method 0 loads position, motion continues.
// - Method 1 adds offset, motion continues.
// - Method 2 captures on externally driven crossing.
// - Method 3 aborts motion, seeks reference itself.
// - Method 3 homes on configured switch edge.
// - Switch methods load commanded position at the edge.
// - Auto-reverse: normal brake, reverse, seek again.
// - No auto-reverse: abort, error, emergency brake.
// - Method value 2 passive, 3 active.
`timescale 1ns/1ps
`default_nettype none
`include "alh_defs.svh"
module alh_supervisor #(
  parameter int unsigned SETTLE_CYCLES = `ALH_SETTLE_CYC
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire alh_pkg::alh_home_cmd_t         homing_command,
  input  wire logic                           hw_limit_config,
  input  wire logic                           sw_limit_config,
  input  wire logic signed [`ALH_POS_W-1:0]   sw_lower_bound,
  input  wire logic signed [`ALH_POS_W-1:0]   sw_upper_bound,
  input  wire logic [`ALH_FILT_W-1:0]         filt_cycles,
  input  wire logic                           home_dir_cfg,
  input  wire logic                           home_edge_cfg,
  input  wire logic                           auto_reverse_cfg,
  input  wire logic                           lower_travel_limit_input,
  input  wire logic                           upper_travel_limit_input,
  input  wire logic                           reference_switch_input,
  input  wire logic                           step_pulse,
  input  wire logic                           step_dir,
  input  wire logic                           axis_standstill,
  input  wire logic                           error_clear,
  output var alh_pkg::alh_drive_req_t         drive_req,
  output logic signed [`ALH_POS_W-1:0]        axis_position,
  output logic                                homed,
  output logic                                error_flag,
  output logic                                homing_busy
);
  import alh_pkg::*;

  logic lim_lo;
  logic lim_up;
  logic ref_lvl;

  alh_in_filter #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_lo (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .raw_in      (lower_travel_limit_input),
    .filt_cycles (filt_cycles),
    .level_out   (lim_lo)
  );
  alh_in_filter #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_up (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .raw_in      (upper_travel_limit_input),
    .filt_cycles (filt_cycles),
    .level_out   (lim_up)
  );
  alh_in_filter #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_ref (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .raw_in      (reference_switch_input),
    .filt_cycles (filt_cycles),
    .level_out   (ref_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Limit evaluation.

  alh_state_t state_reg;
  logic       dir_reg;
  logic       ref_prev_reg;
  logic       ref_rise;
  logic       ref_fall;
  logic       ref_edge;
  logic       hw_trip;
  logic       hw_ahead;
  logic       sw_stop;
  logic       start;
  logic       seeking;

  assign ref_rise = ref_lvl && !ref_prev_reg;
  assign ref_fall = !ref_lvl && ref_prev_reg;
  assign ref_edge = home_edge_cfg ? ref_fall : ref_rise;
  assign start    = homing_command.start;
  assign seeking  = state_reg == ST_SEEK;

  // The switch holds its tripped level, so a plain level check suffices.
  assign hw_trip  = hw_limit_config && (lim_lo || lim_up);
  assign hw_ahead = hw_limit_config && (dir_reg ? lim_up : lim_lo);
  assign sw_stop  = sw_limit_config && homed &&
                    (axis_position <= sw_lower_bound || axis_position >= sw_upper_bound);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Homing sequencer.

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      dir_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start && homing_command.mode == `ALH_MODE_PASSIVE) begin
            state_reg <= ST_PASSIVE;
          end else if (start && homing_command.mode == `ALH_MODE_ACTIVE) begin
            state_reg <= ST_SEEK;
            dir_reg   <= home_dir_cfg;
          end
        end
        ST_SEEK: begin
          if (ref_edge) begin
            state_reg <= ST_IDLE;
          end else if (hw_ahead && auto_reverse_cfg) begin
            state_reg <= ST_TURN;
          end else if (hw_ahead) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_TURN: begin
          if (axis_standstill) begin
            state_reg <= ST_SEEK;
            dir_reg   <= !dir_reg;
          end
        end
        ST_PASSIVE: begin
          if (ref_edge) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign homing_busy = state_reg != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // Axis position and homed flag.

  // Steps keep counting during methods 0 to 2, so ongoing motion is not disturbed.
  function automatic logic signed [`ALH_POS_W-1:0] step_delta(input logic p, input logic d);
    step_delta = p ? (d ? `ALH_POS_W'sd1 : -`ALH_POS_W'sd1) : `ALH_POS_W'sd0;
  endfunction

  logic cap_edge;
  assign cap_edge = (state_reg == ST_SEEK || state_reg == ST_PASSIVE) && ref_edge;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      axis_position <= '0;
    end else if (start && !homing_busy && homing_command.mode == `ALH_MODE_ABS) begin
      axis_position <= homing_command.position;
    end else if (start && !homing_busy && homing_command.mode == `ALH_MODE_REL) begin
      axis_position <= axis_position + homing_command.position + step_delta(step_pulse, step_dir);
    end else if (cap_edge) begin
      axis_position <= homing_command.position;
    end else begin
      axis_position <= axis_position + step_delta(step_pulse, step_dir);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      homed <= 1'b0;
    end else if (cap_edge || (start && !homing_busy && homing_command.mode[1] == 1'b0)) begin
      homed <= 1'b1;
    end else if (start && !homing_busy && homing_command.mode == `ALH_MODE_ACTIVE) begin
      homed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive requests and error flag.

  logic seek_fail;
  assign seek_fail = seeking && hw_ahead && !auto_reverse_cfg && !ref_edge;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_flag <= 1'b0;
    end else if ((hw_trip && !seeking && state_reg != ST_TURN) || seek_fail) begin
      error_flag <= 1'b1;
    end else if (error_clear) begin
      error_flag <= 1'b0;
    end
  end

  // Auto-reverse during a seek replaces the emergency stop by a normal brake.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_req <= '0;
    end else begin
      drive_req.move  <= seeking && !ref_edge && !hw_ahead;
      drive_req.dir   <= dir_reg;
      drive_req.estop <= (hw_trip && !seeking && state_reg != ST_TURN) || seek_fail;
      drive_req.stop  <= sw_stop || state_reg == ST_TURN || (seeking && (ref_edge || hw_ahead));
      drive_req.abort <= start && !homing_busy && homing_command.mode == `ALH_MODE_ACTIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_hw_estop: assert property (hw_trip && state_reg == ST_IDLE |=> drive_req.estop)
    else $error("hardware limit trip without emergency brake");
  a_hw_off_quiet: assert property (!hw_limit_config && !seeking |=> !drive_req.estop)
    else $error("emergency brake while hardware limits disabled");
  a_sw_unhomed: assert property (!homed && state_reg == ST_IDLE |=> !drive_req.stop)
    else $error("software limit acted before homing");
  a_sw_stop_low: assert property (sw_limit_config && homed && axis_position <= sw_lower_bound |=> drive_req.stop)
    else $error("software lower limit not stopping");
  a_abs_load: assert property (start && !homing_busy && homing_command.mode == `ALH_MODE_ABS
                               |=> axis_position == $past(homing_command.position) && homed)
    else $error("absolute homing did not load position");
  a_rel_add: assert property (start && !homing_busy && homing_command.mode == `ALH_MODE_REL && !step_pulse
                              |=> axis_position == $past(axis_position) + $past(homing_command.position))
    else $error("relative homing sum wrong");
  a_active_abort: assert property (start && !homing_busy && homing_command.mode == `ALH_MODE_ACTIVE
                                   |=> drive_req.abort ##1 !drive_req.abort)
    else $error("active homing did not abort motion once");
  a_seek_fail: assert property (seek_fail |=> error_flag && drive_req.estop && state_reg == ST_IDLE)
    else $error("failed seek not flagged");
  a_err_sticky: assert property (error_flag && !error_clear |=> error_flag)
    else $error("error flag dropped without clear");
  a_turn_normal: assert property (state_reg == ST_TURN |=> !drive_req.estop)
    else $error("emergency brake during reversal");

  c_active_home: cover property (seeking ##[1:50] cap_edge);
  c_reverse: cover property (state_reg == ST_TURN ##[1:50] seeking);
  c_passive_home: cover property (state_reg == ST_PASSIVE && cap_edge);
endmodule
`default_nettype wire

/* File: alh_defs.svh */
// Constants for the axis limit and homing supervisor.
// Assumes a 25 MHz system clock; included by alh_pkg and the design modules.
`ifndef ALH_DEFS_SVH
`define ALH_DEFS_SVH
`define ALH_POS_W        32
`define ALH_FILT_W       20
`define ALH_MODE_ABS     2'h0
`define ALH_MODE_REL     2'h1
`define ALH_MODE_PASSIVE 2'h2
`define ALH_MODE_ACTIVE  2'h3
`define ALH_CLK_MHZ      25
`define ALH_SETTLE_US    20000
`define ALH_SETTLE_CYC   (`ALH_SETTLE_US * `ALH_CLK_MHZ)
`endif

/* File: alh_pkg.sv */
// Types shared by the axis limit and homing supervisor.
// Assumes alh_defs.svh is on the include path.
`include "alh_defs.svh"
package alh_pkg;
  typedef struct packed {
    logic                          start;
    logic [1:0]                    mode;
    logic signed [`ALH_POS_W-1:0]  position;
  } alh_home_cmd_t;

  typedef struct packed {
    logic move;
    logic dir;
    logic stop;
    logic estop;
    logic abort;
  } alh_drive_req_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SEEK    = 2'b01,
    ST_TURN    = 2'b10,
    ST_PASSIVE = 2'b11
  } alh_state_t;
endpackage

/* File: alh_in_filter.sv */
// Switch input conditioner: two-stage synchroniser followed by a stability filter.
// Assumes the raw pin is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "alh_defs.svh"
module alh_in_filter #(
  parameter int unsigned SETTLE_CYCLES = `ALH_SETTLE_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   raw_in,
  input  wire logic [`ALH_FILT_W-1:0] filt_cycles,
  output logic                        level_out
);
  import alh_pkg::*;

  logic                   sync1_reg;
  logic                   sync2_reg;
  logic [`ALH_FILT_W-1:0] cnt_reg;
  logic [`ALH_FILT_W-1:0] filt_prev_reg;
  logic                   init_reg;
  logic [31:0]            settle_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // A changed filter time leaves the filter sluggish until enough low level has accumulated.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_reg      <= 1'b0;
      filt_prev_reg <= '0;
      settle_reg    <= 32'h0;
    end else begin
      init_reg      <= 1'b1;
      filt_prev_reg <= filt_cycles;
      if (init_reg && filt_prev_reg != filt_cycles) begin
        settle_reg <= SETTLE_CYCLES;
      end else if (settle_reg != 32'h0 && !sync2_reg) begin
        settle_reg <= settle_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg   <= '0;
      level_out <= 1'b0;
    end else if (sync2_reg == level_out) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= filt_cycles) begin
      cnt_reg <= '0;
      if (sync2_reg || settle_reg == 32'h0) begin
        level_out <= sync2_reg;
      end
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: alh_drive_model.sv */
// Behavioural pulse drive with two limit switches and a reference switch.
// Assumes the bench clock; the carriage position is counted in steps.
`timescale 1ns/1ps
`default_nettype none
module alh_drive_model (
  input  wire logic                    sys_clk,
  input  wire alh_pkg::alh_drive_req_t drive_req,
  input  wire logic                    jog,
  input  wire logic                    jog_dir,
  output logic                         step_pulse,
  output logic                         step_dir,
  output logic                         axis_standstill,
  output logic                         lower_travel_limit_input,
  output logic                         upper_travel_limit_input,
  output logic                         reference_switch_input
);
  import alh_pkg::*;
  int   pos = 0;
  int   div = 0;
  logic run;
  // A slow step rate keeps the switch filter delay shorter than one step.
  assign run = (drive_req.move || jog) && !drive_req.stop && !drive_req.estop;
  // Limits stay tripped for as long as the carriage sits beyond them.
  // The pins reach the supervisor directly, so a trip is seen without polling delay.
  assign lower_travel_limit_input = pos <= -40;
  assign upper_travel_limit_input = pos >= 40;
  assign reference_switch_input = pos >= 20 && pos <= 24;
  always_ff @(posedge sys_clk) begin
    axis_standstill <= !run;
    step_pulse <= 1'b0;
    step_dir <= jog ? jog_dir : drive_req.dir;
    div <= (run && div != 15) ? div + 1 : 0;
    if (run && div == 15) begin
      step_pulse <= 1'b1;
      pos <= (jog ? jog_dir : drive_req.dir) ? pos + 1 : pos - 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the axis limit and homing supervisor.
// Assumes the drive model above stands on the far side of the supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import alh_pkg::*;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  alh_home_cmd_t      cmd = '0;
  logic               hw_en = 1'b0, sw_en = 1'b0, hdir = 1'b0, hedge = 1'b0;
  logic               arev = 1'b0, eclr = 1'b0, jog = 1'b0, jdir = 1'b0;
  logic signed [31:0] lo = 32'h0, hi = 32'h0, pos, exp = 32'h0;
  logic               sp, sd, ss, llim, ulim, rsw, homed, err, busy;
  alh_drive_req_t     dr;
  logic [31:0]        rs = 32'h0000002d;
  logic [19:0]        filt = 20'h00002;
  int                 n_errors = 0, n_tests = 0, i;
  alh_supervisor #(.SETTLE_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .homing_command(cmd), .hw_limit_config(hw_en), .sw_limit_config(sw_en),
    .sw_lower_bound(lo), .sw_upper_bound(hi), .filt_cycles(filt),
    .home_dir_cfg(hdir), .home_edge_cfg(hedge), .auto_reverse_cfg(arev),
    .lower_travel_limit_input(llim), .upper_travel_limit_input(ulim),
    .reference_switch_input(rsw), .step_pulse(sp), .step_dir(sd),
    .axis_standstill(ss), .error_clear(eclr), .drive_req(dr),
    .axis_position(pos), .homed(homed), .error_flag(err), .homing_busy(busy));
  alh_drive_model model_u (.sys_clk(sys_clk), .drive_req(dr), .jog(jog),
    .jog_dir(jdir), .step_pulse(sp), .step_dir(sd), .axis_standstill(ss),
    .lower_travel_limit_input(llim), .upper_travel_limit_input(ulim),
    .reference_switch_input(rsw));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic outside(input logic signed [31:0] p);
    return p <= lo || p >= hi;
  endfunction
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] want, input string m);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %0t %s seen %h want %h", $time, m, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic look(input int n);
    cyc(n);
    @(negedge sys_clk);
  endtask
  task automatic home(input logic [1:0] m, input logic [31:0] p);
    @(posedge sys_clk);
    cmd <= '{1'b1, m, p};
    @(posedge sys_clk);
    cmd.start <= 1'b0;
  endtask
  task automatic idle_wait(input int lim);
    // Busy is read only after the edge that took the command has settled.
    @(negedge sys_clk);
    for (i = 0; i < lim && busy !== 1'b0; i++) @(negedge sys_clk);
    if (busy !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic jog_to(input logic d, input int target);
    jdir <= d;
    jog  <= 1'b1;
    for (i = 0; i < 2000 && model_u.pos != target; i++) @(posedge sys_clk);
    jog <= 1'b0;
    if (model_u.pos != target) begin
      n_errors++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({homed, err, busy, dr, pos}, 0, "reset state");
    cyc(1);
    sw_en <= 1'b1;
    hw_en <= 1'b1;
    lo    <= 32'shc0000000;
    hi    <= 32'sh40000000;
    look(4);
    chk(dr.stop, 0, "soft limit before homing");
    for (int k = 0; k < 6; k++) begin
      rs = xs(rs);
      exp = k[0] ? exp + rs : rs;
      home({1'b0, k[0]}, rs);
      look(1);
      chk(pos, exp, "direct homing");
      chk(homed, 1, "homed flag");
      @(negedge sys_clk);
      chk(dr.stop, outside(exp), "soft limit check");
    end
    cyc(1);
    lo <= exp - 10;
    hi <= exp + 10;
    look(2);
    chk(dr.stop, 0, "new bounds inside");
    cyc(1);
    hi <= exp;
    look(2);
    chk(dr.stop, 1, "upper bound reached");
    cyc(1);
    sw_en <= 1'b0;
    look(2);
    chk(dr.stop, 0, "soft limits off");
    cyc(1);
    arev <= 1'b1;
    rs = xs(rs);
    home(2'h3, rs);
    @(negedge sys_clk);
    chk({dr.abort, busy, homed}, 3'b110, "active start");
    @(negedge sys_clk);
    chk({dr.abort, dr.move, dr.dir}, {2'b01, hdir}, "active seek");
    idle_wait(4000);
    look(3);
    chk({err, homed}, 2'b01, "reverse at limit");
    chk(pos, signed'(32'(rs + model_u.pos - 20)), "active capture");
    cyc(1);
    arev <= 1'b0;
    hdir <= 1'b1;
    home(2'h3, rs);
    idle_wait(2000);
    look(1);
    chk({err, dr.estop, homed}, 3'b110, "limit without reverse");
    cyc(1);
    hw_en <= 1'b0;
    look(3);
    chk(dr.estop, 0, "hard limits off");
    cyc(1);
    eclr <= 1'b1;
    cyc(1);
    eclr <= 1'b0;
    look(1);
    chk(err, 0, "error cleared");
    cyc(1);
    jog_to(1'b0, 0);
    hedge <= 1'b1;
    rs = xs(rs);
    home(2'h2, rs);
    @(negedge sys_clk);
    chk({busy, dr.abort, dr.move}, 3'b100, "passive start");
    cyc(1);
    jdir <= 1'b1;
    jog <= 1'b1;
    idle_wait(2000);
    cyc(1);
    jog <= 1'b0;
    look(3);
    chk(homed, 1, "passive homed");
    chk(pos, signed'(32'(rs + model_u.pos - 25)), "passive capture");
    // A new filter time taken while the limit is tripped holds back its release.
    cyc(1);
    jog_to(1'b1, 40);
    cyc(8);
    filt <= 20'h00003;
    cyc(4);
    jog_to(1'b0, 39);
    hw_en <= 1'b1;
    look(8);
    chk(dr.estop, 1, "release held after filter change");
    look(30);
    chk(dr.estop, 0, "release after settling");
    // A power cycle after a filter change makes the release immediate again.
    cyc(1);
    jog_to(1'b1, 40);
    cyc(8);
    filt <= 20'h00002;
    cyc(4);
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({homed, err, busy, dr, pos}, 0, "power cycle state");
    look(8);
    chk(dr.estop, 1, "limit seen after power cycle");
    cyc(1);
    hw_en <= 1'b0;
    cyc(1);
    jog_to(1'b0, 39);
    hw_en <= 1'b1;
    look(8);
    chk(dr.estop, 0, "release immediate after power cycle");
    end_of_test();
  end
endmodule
`default_nettype wire
